// ### flags_pkg.sv
// Purpose: Shared constants and carriers for the status and arithmetic-control block.
// Assumes: 32-bit sum and product, 16-bit multiplicand, 16-bit stack pointer.
// Notes: Shift selector codes are chosen here; see mul_shift_select values.
package flags_pkg;

    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int TALLY_W = 6;
    localparam int SEL_W = 3;
    localparam int CNT_W = 4;
    localparam int OFS_W = 6;

    // Status word zero field positions
    localparam int ST0_SIGN_EXT_POS = 0;
    localparam int ST0_SATURATE_POS = 1;
    localparam int ST0_WRAP_POS = 2;
    localparam int ST0_NEG_POS = 5;
    localparam int ST0_SHIFT_POS = 7;
    localparam int ST0_TALLY_POS = 10;
    // Status word one field positions
    localparam int ST1_PAGE_ZERO_SELECT_POS = 0;
    localparam int ST1_LOOP_POS = 1;

    // Reset values
    localparam logic [HALF_W-1:0] ST0_RESET = 16'h0000;
    localparam logic PAGE_ZERO_SELECT_RESET = 1'b0;
    localparam logic [HALF_W-1:0] T_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] SUM_RESET = 32'h0000_0000;

    localparam logic [DATA_W-1:0] SAT_POS = 32'h7fff_ffff;
    localparam logic [DATA_W-1:0] SAT_NEG = 32'h8000_0000;

    // Product shift choices
    typedef enum logic [SEL_W-1:0] {
        PSH_LEFT1 = 3'b000,
        PSH_NONE  = 3'b001,
        PSH_RIGHT1 = 3'b010,
        PSH_RIGHT2 = 3'b011,
        PSH_RIGHT3 = 3'b100,
        PSH_RIGHT4 = 3'b101,
        PSH_RIGHT5 = 3'b110,
        PSH_RIGHT6 = 3'b111
    } mul_shift_e;

    // Operations issued by decode
    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_ADD       = 4'h1,
        OP_SUB       = 4'h2,
        OP_LOAD_SUM  = 4'h3,
        OP_MUL_P     = 4'h4,
        OP_MUL_SUM   = 4'h5,
        OP_ASR       = 4'h6,
        OP_LSL       = 4'h7,
        OP_LSR       = 4'h8,
        OP_SUM_SHR   = 4'h9,
        OP_CLAMP     = 4'ha,
        OP_ADD_PROD  = 4'hb,
        OP_LOAD_T    = 4'hc
    } op_e;

    typedef struct packed {
        op_e op;
        logic [DATA_W-1:0] operand;
        logic [HALF_W-1:0] mul_operand;
    } op_req_s;

    typedef struct packed {
        logic branch_clear;
        logic st0_wr;
        logic [HALF_W-1:0] st0_wdata;
        logic st1_page_zero_select_wr;
        logic st1_page_zero_select_wdata;
    } ctl_req_s;

    typedef struct packed {
        logic [HALF_W-1:0] base;
        logic [OFS_W-1:0] offset;
        logic [HALF_W-1:0] data_page_ptr;
        logic [HALF_W-1:0] stack_ptr;
    } addr_req_s;

endpackage

// ### shift_unit.sv
// Purpose: Barrel shifter for the sum register shifts; product scaling is done in status_flags.
// Assumes: Count already limited to its field width by the caller.
// Notes: Arithmetic fill when arith is set: always for OP_ASR, for OP_SUM_SHR only when sign extension is enabled.
`timescale 1ns/1ps
module shift_unit (
    // Operand
    input wire logic [flags_pkg::DATA_W-1:0] value,
    input wire logic [flags_pkg::CNT_W-1:0] count,
    // Control
    input wire logic left,
    input wire logic arith,
    // Result
    output logic [flags_pkg::DATA_W-1:0] result
);
    import flags_pkg::*;

    always_comb begin
        if (left) begin
            result = value << count;
        end else if (arith) begin
            result = DATA_W'($signed(value) >>> count);
        end else begin
            result = value >> count;
        end
    end
endmodule

// ### status_flags.sv
// Purpose: Result flags, wrap tally, saturation, product shift and page-zero addressing.
// Assumes: Decode presents at most one operation per cycle; all inputs on clk_sys.
// Notes: Products are held in the product register unless sent to the sum register.
`timescale 1ns/1ps
module status_flags (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Operation from decode
    input wire flags_pkg::op_req_s op_req,
    input wire flags_pkg::ctl_req_s ctl_req,
    input wire logic repeat_while_nonzero,
    input wire logic repeat_while_zero,
    // Addressing
    input wire flags_pkg::addr_req_s addr_req,
    output logic [flags_pkg::HALF_W-1:0] direct_addr,
    output logic [flags_pkg::HALF_W-1:0] stack_addr,
    // Status
    output logic [flags_pkg::HALF_W-1:0] status_word_zero,
    output logic [flags_pkg::HALF_W-1:0] status_word_one,
    output logic [flags_pkg::DATA_W-1:0] main_sum_reg,
    output logic [flags_pkg::HALF_W-1:0] mul_result_high,
    output logic [flags_pkg::HALF_W-1:0] mul_result_low,
    output logic [flags_pkg::HALF_W-1:0] mul_operand_reg,
    output logic [flags_pkg::DATA_W-1:0] scaled_product
);
    import flags_pkg::*;

    logic [DATA_W-1:0] sum_q;
    logic [DATA_W-1:0] prod_q;
    logic [HALF_W-1:0] mreg_q;
    logic [TALLY_W-1:0] wrap_tally_q;
    logic saturate_enable_q;
    logic sign_extend_enable_q;
    logic wrap_q;
    logic neg_q;
    logic [SEL_W-1:0] mul_shift_select_q;
    logic page_zero_select_q;
    logic loop_q;

    logic [DATA_W-1:0] prod_full;
    logic [DATA_W-1:0] prod_scaled;
    logic [DATA_W-1:0] shift_out;
    logic [CNT_W-1:0] shift_cnt;
    logic shift_left;
    logic [DATA_W:0] wide_sum;
    logic [DATA_W-1:0] result;
    logic arith_op;
    logic pos_ovf;
    logic neg_ovf;
    logic writes_sum;
    logic [DATA_W-1:0] sum_d;

    // Two's-complement overflow of a 32-bit add given operands and sum
    function automatic logic [1:0] ovf_dir(input logic a, input logic b, input logic s);
        ovf_dir = {~a & ~b & s, a & b & ~s};
    endfunction

    // Operands widened by hand so the product keeps all 32 bits
    assign prod_full = {{HALF_W{mreg_q[HALF_W-1]}}, mreg_q}
                       * {{HALF_W{op_req.mul_operand[HALF_W-1]}}, op_req.mul_operand};

    // Product scaling; codes picked so the count is simply the code minus one
    always_comb begin
        case (mul_shift_select_q)
            PSH_LEFT1: prod_scaled = prod_q << 1;
            PSH_NONE: prod_scaled = prod_q;
            default: begin
                if (sign_extend_enable_q) begin
                    prod_scaled = DATA_W'($signed(prod_q) >>> (mul_shift_select_q - 3'd1));
                end else begin
                    prod_scaled = prod_q >> (mul_shift_select_q - 3'd1);
                end
            end
        endcase
    end

    assign shift_cnt = mreg_q[CNT_W-1:0];
    assign shift_left = (op_req.op == OP_LSL);

    shift_unit u_shift (
        .value(sum_q),
        .count(shift_cnt),
        .left(shift_left),
        .arith((op_req.op == OP_ASR) ||
               (op_req.op == OP_SUM_SHR && sign_extend_enable_q)),
        .result(shift_out)
    );

    // Result path and overflow detection
    always_comb begin
        wide_sum = '0;
        result = sum_q;
        arith_op = 1'b0;
        writes_sum = 1'b1;
        case (op_req.op)
            OP_ADD: begin
                wide_sum = {1'b0, sum_q} + {1'b0, op_req.operand};
                result = wide_sum[DATA_W-1:0];
                arith_op = 1'b1;
            end
            OP_SUB: begin
                wide_sum = {1'b0, sum_q} + {1'b0, ~op_req.operand} + 33'h1;
                result = wide_sum[DATA_W-1:0];
                arith_op = 1'b1;
            end
            OP_ADD_PROD: begin
                wide_sum = {1'b0, sum_q} + {1'b0, prod_scaled};
                result = wide_sum[DATA_W-1:0];
                arith_op = 1'b1;
            end
            OP_LOAD_SUM: result = op_req.operand;
            OP_MUL_SUM: result = prod_full;
            OP_ASR, OP_LSL, OP_LSR, OP_SUM_SHR: result = shift_out;
            OP_CLAMP: begin
                // Positive tally saturates high, negative low, zero leaves the sum alone
                if (wrap_tally_q[TALLY_W-1]) begin
                    result = SAT_NEG;
                end else if (wrap_tally_q != '0) begin
                    result = SAT_POS;
                end
            end
            default: writes_sum = 1'b0;
        endcase
    end

    always_comb begin
        pos_ovf = 1'b0;
        neg_ovf = 1'b0;
        if (arith_op) begin
            if (op_req.op == OP_SUB) begin
                {pos_ovf, neg_ovf} = ovf_dir(sum_q[DATA_W-1], ~op_req.operand[DATA_W-1],
                                             result[DATA_W-1]);
            end else if (op_req.op == OP_ADD) begin
                {pos_ovf, neg_ovf} = ovf_dir(sum_q[DATA_W-1], op_req.operand[DATA_W-1],
                                             result[DATA_W-1]);
            end else begin
                {pos_ovf, neg_ovf} = ovf_dir(sum_q[DATA_W-1], prod_scaled[DATA_W-1],
                                             result[DATA_W-1]);
            end
        end
    end

    // Saturation picks the stored value, so the negative flag follows what is kept
    always_comb begin
        sum_d = result;
        if (saturate_enable_q && pos_ovf) begin
            sum_d = SAT_POS;
        end else if (saturate_enable_q && neg_ovf) begin
            sum_d = SAT_NEG;
        end
    end

    // Sum register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sum_q <= SUM_RESET;
        end else if (writes_sum) begin
            sum_q <= sum_d;
        end
    end

    // Product and multiplicand registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            prod_q <= SUM_RESET;
            mreg_q <= T_RESET;
        end else begin
            if (op_req.op == OP_MUL_P) begin
                prod_q <= prod_full;
            end
            if (op_req.op == OP_LOAD_T) begin
                mreg_q <= op_req.mul_operand;
            end
        end
    end

    // Status word zero: software write, then hardware updates win
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sign_extend_enable_q <= ST0_RESET[ST0_SIGN_EXT_POS];
            saturate_enable_q <= ST0_RESET[ST0_SATURATE_POS];
            wrap_q <= ST0_RESET[ST0_WRAP_POS];
            neg_q <= ST0_RESET[ST0_NEG_POS];
            mul_shift_select_q <= ST0_RESET[ST0_SHIFT_POS +: SEL_W];
            wrap_tally_q <= ST0_RESET[ST0_TALLY_POS +: TALLY_W];
        end else begin
            if (ctl_req.st0_wr) begin
                sign_extend_enable_q <= ctl_req.st0_wdata[ST0_SIGN_EXT_POS];
                saturate_enable_q <= ctl_req.st0_wdata[ST0_SATURATE_POS];
                wrap_q <= ctl_req.st0_wdata[ST0_WRAP_POS];
                neg_q <= ctl_req.st0_wdata[ST0_NEG_POS];
                mul_shift_select_q <= ctl_req.st0_wdata[ST0_SHIFT_POS +: SEL_W];
                wrap_tally_q <= ctl_req.st0_wdata[ST0_TALLY_POS +: TALLY_W];
            end else if (ctl_req.branch_clear) begin
                wrap_q <= 1'b0;
            end
            if (writes_sum) begin
                neg_q <= sum_d[DATA_W-1];
            end
            if (pos_ovf || neg_ovf) begin
                wrap_q <= 1'b1;
            end
            if (!saturate_enable_q) begin
                if (pos_ovf) begin
                    wrap_tally_q <= wrap_tally_q + 6'h01;
                end else if (neg_ovf) begin
                    wrap_tally_q <= wrap_tally_q - 6'h01;
                end
            end
        end
    end

    // Status word one
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            page_zero_select_q <= PAGE_ZERO_SELECT_RESET;
            loop_q <= 1'b0;
        end else begin
            if (ctl_req.st1_page_zero_select_wr) begin
                page_zero_select_q <= ctl_req.st1_page_zero_select_wdata;
            end
            loop_q <= repeat_while_nonzero | repeat_while_zero;
        end
    end

    // Address formation, registered
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            direct_addr <= '0;
            stack_addr <= '0;
        end else begin
            direct_addr <= page_zero_select_q ? addr_req.base
                                              : (addr_req.data_page_ptr | addr_req.base);
            stack_addr <= page_zero_select_q ? addr_req.stack_ptr
                                             : addr_req.stack_ptr
                                               - {{(HALF_W-OFS_W){1'b0}}, addr_req.offset};
        end
    end

    always_comb begin
        status_word_zero = '0;
        status_word_zero[ST0_SIGN_EXT_POS] = sign_extend_enable_q;
        status_word_zero[ST0_SATURATE_POS] = saturate_enable_q;
        status_word_zero[ST0_WRAP_POS] = wrap_q;
        status_word_zero[ST0_NEG_POS] = neg_q;
        status_word_zero[ST0_SHIFT_POS +: SEL_W] = mul_shift_select_q;
        status_word_zero[ST0_TALLY_POS +: TALLY_W] = wrap_tally_q;
        status_word_one = '0;
        status_word_one[ST1_PAGE_ZERO_SELECT_POS] = page_zero_select_q;
        status_word_one[ST1_LOOP_POS] = loop_q;
    end

    assign main_sum_reg = sum_q;
    assign mul_result_high = prod_q[DATA_W-1:HALF_W];
    assign mul_result_low = prod_q[HALF_W-1:0];
    assign mul_operand_reg = mreg_q;
    assign scaled_product = prod_scaled;
endmodule

// ### status_flags_assertions.sv
// Purpose: Port-level checks on status_flags.
// Assumes: One clock, srst synchronous and active high.
// Notes: Positive overflow is rebuilt here for plain adds only.
`timescale 1ns/1ps
module status_flags_assertions (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Requests
    input wire flags_pkg::op_req_s op_req,
    input wire flags_pkg::ctl_req_s ctl_req,
    input wire logic repeat_while_nonzero,
    input wire logic repeat_while_zero,
    input wire flags_pkg::addr_req_s addr_req,
    // Results
    input wire logic [flags_pkg::HALF_W-1:0] direct_addr,
    input wire logic [flags_pkg::HALF_W-1:0] stack_addr,
    input wire logic [flags_pkg::HALF_W-1:0] status_word_zero,
    input wire logic [flags_pkg::HALF_W-1:0] status_word_one,
    input wire logic [flags_pkg::DATA_W-1:0] main_sum_reg,
    input wire logic [flags_pkg::HALF_W-1:0] mul_result_high,
    input wire logic [flags_pkg::HALF_W-1:0] mul_result_low,
    input wire logic [flags_pkg::HALF_W-1:0] mul_operand_reg
);
    import flags_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic [DATA_W-1:0] add_r;
    logic [DATA_W-1:0] prod_d;
    logic [HALF_W-1:0] sa_d;
    logic pos_ovf;
    logic loop_in;
    logic clip;
    logic [TALLY_W-1:0] tally;
    assign add_r = main_sum_reg + op_req.operand;
    assign pos_ovf = (op_req.op == OP_ADD) && !main_sum_reg[31] && !op_req.operand[31] && add_r[31];
    assign prod_d = $signed(mul_operand_reg) * $signed(op_req.mul_operand);
    assign sa_d = addr_req.stack_ptr - {10'h000, addr_req.offset};
    assign loop_in = repeat_while_nonzero || repeat_while_zero;
    assign clip = status_word_zero[ST0_SATURATE_POS];
    assign tally = status_word_zero[ST0_TALLY_POS +: TALLY_W];
    property p_neg;
        op_req.op inside {OP_ADD, OP_SUB, OP_LOAD_SUM, OP_ASR, OP_LSL}
            |=> status_word_zero[ST0_NEG_POS] == main_sum_reg[31];
    endproperty
    a_neg: assert property (p_neg) else $error("negative flag differs from sum top bit");
    property p_wrap_hold;
        status_word_zero[ST0_WRAP_POS] && !ctl_req.branch_clear && !ctl_req.st0_wr
            |=> status_word_zero[ST0_WRAP_POS];
    endproperty
    a_wrap_hold: assert property (p_wrap_hold) else $error("wrap flag dropped");
    property p_tally_frozen;
        clip && !ctl_req.st0_wr |=> $stable(tally);
    endproperty
    a_tally_frozen: assert property (p_tally_frozen) else $error("tally moved while clipping");
    property p_tally_inc;
        !clip && pos_ovf && !ctl_req.st0_wr |=> tally == $past(tally) + 6'h01;
    endproperty
    a_tally_inc: assert property (p_tally_inc) else $error("tally not incremented");
    property p_clip;
        clip && pos_ovf |=> main_sum_reg == SAT_POS && status_word_zero[ST0_WRAP_POS];
    endproperty
    a_clip: assert property (p_clip) else $error("sum not clipped");
    property p_loop;
        1'b1 |=> status_word_one[ST1_LOOP_POS] == $past(loop_in);
    endproperty
    a_loop: assert property (p_loop) else $error("loop bit wrong");
    property p_page_zero_select;
        status_word_one[ST1_PAGE_ZERO_SELECT_POS] |=> direct_addr == $past(addr_req.base);
    endproperty
    a_page_zero_select: assert property (p_page_zero_select) else $error("direct address not on page zero");
    property p_stack;
        !status_word_one[ST1_PAGE_ZERO_SELECT_POS] |=> stack_addr == $past(sa_d);
    endproperty
    a_stack: assert property (p_stack) else $error("stack address wrong");
    property p_prod;
        op_req.op == OP_MUL_P
            |=> {mul_result_high, mul_result_low} == $past(prod_d) && $stable(main_sum_reg);
    endproperty
    a_prod: assert property (p_prod) else $error("product misplaced");
    c_clip: cover property (clip && pos_ovf);
    c_clamp: cover property (op_req.op == OP_CLAMP && tally != 6'h00);
    c_loop: cover property (repeat_while_nonzero && !repeat_while_zero);
endmodule

// ### decode_model.sv
// Purpose: Stand-in for decode and pipeline control.
// Assumes: Requests change only on the falling edge.
// Notes: Each request stands one cycle, as decode issues them.
`timescale 1ns/1ps
module decode_model (
    // Clock
    input wire logic clk_sys,
    // Requests
    output flags_pkg::op_req_s op_req,
    output flags_pkg::ctl_req_s ctl_req,
    output logic repeat_while_nonzero,
    output logic repeat_while_zero,
    output flags_pkg::addr_req_s addr_req
);
    import flags_pkg::*;
    initial begin
        op_req = '0;
        ctl_req = '0;
        repeat_while_nonzero = 1'b0;
        repeat_while_zero = 1'b0;
        addr_req = '0;
    end
    task automatic drive(input op_req_s o, input ctl_req_s c, input logic nz, z,
                         input addr_req_s a);
        @(negedge clk_sys);
        op_req = o;
        ctl_req = c;
        repeat_while_nonzero = nz;
        repeat_while_zero = z;
        addr_req = a;
    endtask
endmodule

// ### status_flags_tb.sv
// Purpose: Self-checking bench for status_flags.
// Assumes: Results land one edge after each request.
// Notes: A reference model predicts every register after each request.
`timescale 1ns/1ps
module status_flags_tb;
    import flags_pkg::*;
    typedef struct packed {
        logic [31:0] sum, p, sc;
        logic [15:0] s0, s1, t, da, sa;
    } exp_s;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    op_req_s op_req;
    ctl_req_s ctl_req;
    logic repeat_while_nonzero, repeat_while_zero;
    addr_req_s addr_req;
    logic [15:0] da, sa, s0, s1, hi, lo, tq;
    logic [31:0] sum, sc, m_sum, m_p;
    logic [15:0] m_t, m_da, m_sa;
    logic [5:0] m_tally;
    logic [2:0] m_sel;
    logic m_neg, m_wrap, m_clip, m_sext, m_pg, m_loop;
    exp_s q[$];
    int err_count = 0;
    int tests_run = 0;
    int seed = 60483;
    op_e dk[6] = '{OP_LOAD_SUM, OP_ADD, OP_ADD, OP_CLAMP, OP_LOAD_SUM, OP_SUB};
    logic [31:0] dx[6] = '{32'h7fff_ffff, 32'h1, 32'h1, 32'h0, 32'h8000_0000, 32'h1};
    always #5 clk_sys = ~clk_sys;
    decode_model pm (.clk_sys, .op_req, .ctl_req, .repeat_while_nonzero,
                     .repeat_while_zero, .addr_req);
    status_flags dut (.clk_sys, .srst, .op_req, .ctl_req, .repeat_while_nonzero,
        .repeat_while_zero, .addr_req, .direct_addr(da), .stack_addr(sa),
        .status_word_zero(s0), .status_word_one(s1), .main_sum_reg(sum),
        .mul_result_high(hi), .mul_result_low(lo), .mul_operand_reg(tq), .scaled_product(sc));
    task automatic chk(input string n, input logic [31:0] s, e);
        tests_run++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask
    function automatic logic [31:0] scl(input logic [31:0] p);
        if (m_sel == PSH_LEFT1) return p << 1;
        if (m_sel == PSH_NONE) return p;
        if (m_sext) return $signed(p) >>> (m_sel - 3'h1);
        return p >> (m_sel - 3'h1);
    endfunction
    task automatic model(input op_req_s o, input ctl_req_s c, input logic l, input addr_req_s a);
        logic [31:0] r, x;
        logic b, up, dn, wr;
        logic [3:0] n;
        r = m_sum;
        wr = 1'b1;
        n = m_t[3:0];
        x = (o.op == OP_ADD_PROD) ? scl(m_p) : o.operand;
        b = (o.op == OP_SUB) ^ x[31];
        m_da = m_pg ? a.base : (a.data_page_ptr | a.base);
        m_sa = m_pg ? a.stack_ptr : a.stack_ptr - 16'(a.offset);
        if (c.st1_page_zero_select_wr) m_pg = c.st1_page_zero_select_wdata;
        m_loop = l;
        if (c.st0_wr) {m_tally, m_sel, m_neg, m_wrap, m_clip, m_sext} =
            {c.st0_wdata[15:7], c.st0_wdata[5], c.st0_wdata[2:0]};
        else if (c.branch_clear) m_wrap = 1'b0;
        case (o.op)
            OP_ADD, OP_SUB, OP_ADD_PROD: begin
                r = (o.op == OP_SUB) ? m_sum - x : m_sum + x;
                up = !m_sum[31] && !b && r[31];
                dn = m_sum[31] && b && !r[31];
                if (up || dn) begin
                    m_wrap = 1'b1;
                    if (m_clip) r = up ? SAT_POS : SAT_NEG;
                    else m_tally = up ? m_tally + 6'h01 : m_tally - 6'h01;
                end
            end
            OP_LOAD_SUM: r = o.operand;
            OP_MUL_P: begin
                m_p = $signed(m_t) * $signed(o.mul_operand);
                wr = 1'b0;
            end
            OP_MUL_SUM: r = $signed(m_t) * $signed(o.mul_operand);
            OP_ASR: r = $signed(m_sum) >>> n;
            OP_LSL: r = m_sum << n;
            OP_LSR: r = m_sum >> n;
            OP_SUM_SHR: if (m_sext) r = $signed(m_sum) >>> n; else r = m_sum >> n;
            OP_CLAMP: if (m_tally != 6'h00) r = m_tally[5] ? SAT_NEG : SAT_POS;
            OP_LOAD_T: begin
                m_t = o.mul_operand;
                wr = 1'b0;
            end
            default: wr = 1'b0;
        endcase
        m_sum = r;
        if (wr) m_neg = r[31];
        q.push_back('{m_sum, m_p, scl(m_p), {m_tally, m_sel, 1'b0, m_neg, 2'b00, m_wrap,
            m_clip, m_sext}, {14'h0, m_loop, m_pg}, m_t, m_da, m_sa});
    endtask
    task automatic step(input op_req_s o, input ctl_req_s c, input logic nz, z,
                        input addr_req_s a);
        pm.drive(o, c, nz, z, a);
        model(o, c, nz | z, a);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        exp_s e;
        #1;
        if (q.size() > 0) begin
            e = q.pop_front();
            chk("main_sum_reg", sum, e.sum);
            chk("status_word_zero", s0, e.s0);
            chk("status_word_one", s1, e.s1);
            chk("product", {hi, lo}, e.p);
            chk("scaled_product", sc, e.sc);
            chk("mul_operand_reg", tq, e.t);
            chk("direct_addr", da, e.da);
            chk("stack_addr", sa, e.sa);
        end
    end
    // About 420 requests are issued; five times that span is ample
    initial begin
        #20000;
        err_count++;
        conclude();
    end
    initial begin
        op_req_s o;
        ctl_req_s c;
        addr_req_s a;
        logic [31:0] r;
        {m_sum, m_p, m_t, m_tally, m_sel, m_neg, m_wrap, m_clip, m_sext, m_pg, m_loop} = '0;
        repeat (5) @(negedge clk_sys);
        srst = 1'b0;
        step('0, '0, 1'b0, 1'b0, '0);
        // Wrap at the limit, first counting, then clipping
        for (int j = 0; j < 2; j++) begin
            c = '0;
            c.st0_wr = 1'b1;
            c.st0_wdata = j ? 16'h0002 : 16'h0000;
            step('0, c, 1'b0, 1'b0, '0);
            for (int i = 0; i < 6; i++) begin
                o = '0;
                o.op = dk[i];
                o.operand = dx[i];
                step(o, '0, 1'b0, 1'b0, '0);
            end
        end
        for (int i = 0; i < 400; i++) begin
            o.operand = $random(seed);
            o.mul_operand = 16'($random(seed));
            o.op = op_e'(4'($unsigned($random(seed)) % 13));
            c = 20'($random(seed));
            c.st0_wr = ($random(seed) & 7) == 0;
            if (c.st0_wr) o.op = OP_NONE;
            a = 54'({$random(seed), $random(seed)});
            r = $random(seed);
            step(o, c, r[0], r[1], a);
        end
        repeat (3) @(negedge clk_sys);
        conclude();
    end
endmodule
bind status_flags status_flags_assertions chk (.clk_sys, .srst, .op_req, .ctl_req,
    .repeat_while_nonzero, .repeat_while_zero, .addr_req, .direct_addr, .stack_addr,
    .status_word_zero, .status_word_one, .main_sum_reg, .mul_result_high,
    .mul_result_low, .mul_operand_reg);
